// ---- common/pcss_pkg.sv ----
// package for the processor clock source select block
package pcss_pkg;

    localparam int unsigned CLK_FREQ_HZ    = 25_000_000;
    localparam int unsigned GAP_CYCLES     = 2;
    localparam int unsigned SLOW_DIV       = 16;
    localparam int unsigned SLOW_CNT_W     = $clog2(SLOW_DIV);
    localparam int unsigned MULT_W         = 4;
    localparam int unsigned UNIT_W         = 8;
    localparam logic [MULT_W-1:0] MULT_RST = 4'h1;
    localparam logic [1:0] GAP_LAST        = 2'(GAP_CYCLES - 1);

    typedef enum logic [1:0] {
        SRC_EXT,
        SRC_SYNTH,
        SRC_SLOW
    } pcss_src_t;

    typedef struct packed {
        logic              synth_pwr_req;
        logic              synth_sel_req;
        logic              slow_sel_req;
        logic [MULT_W-1:0] synth_mult;
        logic [UNIT_W-1:0] unit_gate;
    } pcss_ctl_t;

    typedef struct packed {
        pcss_src_t         src;
        logic              switching;
        logic              synth_pwr_en;
        logic              synth_locked;
        logic [MULT_W-1:0] synth_mult;
    } pcss_stat_t;

endpackage

// ---- hdl/pcss_slow_div.sv ----
// internal slow clock generator, one tick per divide period
`timescale 1ns/1ns
module pcss_slow_div
    import pcss_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      slow_tick
);

    logic [SLOW_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_tick <= 1'b0;
        end else begin
            slow_tick <= (cnt_q == '1);
        end
    end

endmodule

// ---- hdl/pcss_top.sv ----
// processor clock source select: ext 1x, synthesizer, slow clock
// How it works
// RULE_01 - power up on undivided external input clock
// RULE_02 - synthesizer output is input clock multiple
// RULE_03 - reset deselects and powers down synthesizer
// RULE_04 - software may select slow clock for power
// RULE_05 - slow clock wins over selected synthesizer
// RULE_06 - synthesizer keeps running while slow overrides
// RULE_07 - power control gates peripheral unit clocks
// RULE_08 - halt pin stops processor clock while asserted
// RULE_09 - switch sources without runts or glitches
`timescale 1ns/1ns
module pcss_top
    import pcss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire pcss_ctl_t   ctl,
    input  wire logic        halt_pin,
    input  wire logic        synth_lock_pin,
    output logic             proc_tick_q,
    output logic [UNIT_W-1:0] periph_en_q,
    output pcss_stat_t       stat
);

    typedef enum logic [1:0] {
        ST_EXT,
        ST_SYNTH,
        ST_SLOW,
        ST_GAP
    } pcss_state_t;

    logic              rst_s1_q;
    logic              rst_n;
    logic              halt_s1_q;
    logic              halt_s2_q;
    logic              lock_s1_q;
    logic              lock_s2_q;
    logic              slow_tick;
    logic              synth_pwr_q;
    logic [MULT_W-1:0] synth_mult_q;
    pcss_state_t       state_q;
    pcss_state_t       state_d;
    pcss_state_t       target;
    pcss_state_t       pend_q;
    logic [1:0]        gap_q;
    logic              tick_d;

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_s1_q <= 1'b0;
            halt_s2_q <= 1'b0;
        end else begin
            halt_s1_q <= halt_pin;
            halt_s2_q <= halt_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            lock_s1_q <= synth_lock_pin;
            lock_s2_q <= lock_s1_q;
        end
    end

    pcss_slow_div u_slow_div (
        .clk       (clk),
        .rst_n     (rst_n),
        .slow_tick (slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // synthesizer power and multiplier

    // power follows the request alone, so a slow override leaves it running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_pwr_q <= 1'b0; // see RULE_03
        end else begin
            synth_pwr_q <= ctl.synth_pwr_req; // see RULE_06
        end
    end

    // zero would not be a multiple, keep the previous ratio instead
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_mult_q <= MULT_RST;
        end else if (ctl.synth_mult != '0) begin
            synth_mult_q <= ctl.synth_mult; // see RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source selection, slow first, synthesizer only once locked

    always_comb begin
        if (ctl.slow_sel_req) begin
            target = ST_SLOW; // see RULE_04 see RULE_05
        end else if (ctl.synth_sel_req && synth_pwr_q && lock_s2_q) begin
            target = ST_SYNTH;
        end else begin
            target = ST_EXT;
        end
    end

    // every change passes a quiet gap so no partial period escapes
    always_comb begin
        state_d = state_q;
        if (state_q == ST_GAP) begin
            if (gap_q == '0) begin
                state_d = pend_q;
            end
        end else if (target != state_q) begin
            state_d = ST_GAP; // see RULE_09
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_EXT; // see RULE_01 see RULE_03
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= ST_EXT;
            gap_q  <= '0;
        end else if (state_q != ST_GAP && state_d == ST_GAP) begin
            pend_q <= target;
            gap_q  <= GAP_LAST;
        end else if (gap_q != '0) begin
            gap_q  <= gap_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor and peripheral clock ticks

    always_comb begin
        unique case (state_q)
            ST_EXT:   tick_d = 1'b1; // see RULE_01
            ST_SYNTH: tick_d = lock_s2_q; // see RULE_02
            ST_SLOW:  tick_d = slow_tick; // see RULE_04
            ST_GAP:   tick_d = 1'b0; // see RULE_09
        endcase
        if (halt_s2_q) begin
            tick_d = 1'b0; // see RULE_08
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_tick_q <= 1'b0;
        end else begin
            proc_tick_q <= tick_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_en_q <= '0;
        end else begin
            periph_en_q <= {UNIT_W{tick_d}} & ~ctl.unit_gate; // see RULE_07
        end
    end

    always_comb begin
        stat.src          = (state_q == ST_SLOW)  ? SRC_SLOW :
                            (state_q == ST_SYNTH) ? SRC_SYNTH : SRC_EXT;
        stat.switching    = (state_q == ST_GAP);
        stat.synth_pwr_en = synth_pwr_q;
        stat.synth_locked = lock_s2_q;
        stat.synth_mult   = synth_mult_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_reset_ext: assert property ( // see RULE_01
        @(posedge clk) disable iff (!rst_n)
        $past(!rst_n) |-> (state_q == ST_EXT))
        else $error("not on external clock after reset");

    chk_reset_synth_off: assert property ( // see RULE_03
        @(posedge clk) disable iff (!rst_n)
        $past(!rst_n) |-> (!synth_pwr_q && state_q != ST_SYNTH))
        else $error("synthesizer active after reset");

    chk_ext_ticks: assert property ( // see RULE_01
        @(posedge clk) disable iff (!rst_n)
        (state_q == ST_EXT && !halt_s2_q) |=> proc_tick_q)
        else $error("external source missed a tick");

    chk_mult_nonzero: assert property ( // see RULE_02
        @(posedge clk) disable iff (!rst_n)
        (ctl.synth_mult != '0) |=> (synth_mult_q == $past(ctl.synth_mult)))
        else $error("multiplier not taken");

    chk_slow_wins: assert property ( // see RULE_05
        @(posedge clk) disable iff (!rst_n)
        ctl.slow_sel_req [*6] |-> (state_q == ST_SLOW))
        else $error("slow clock did not take over");

    chk_slow_only_ticks: assert property ( // see RULE_04
        @(posedge clk) disable iff (!rst_n)
        (state_q == ST_SLOW && !slow_tick) |=> !proc_tick_q)
        else $error("tick outside slow period");

    chk_synth_keeps: assert property ( // see RULE_06
        @(posedge clk) disable iff (!rst_n)
        (ctl.synth_pwr_req && ctl.slow_sel_req) |=> synth_pwr_q)
        else $error("synthesizer stopped under slow override");

    chk_unit_gate: assert property ( // see RULE_07
        @(posedge clk) disable iff (!rst_n)
        (ctl.unit_gate != '0) |=> ((periph_en_q & $past(ctl.unit_gate)) == '0))
        else $error("gated unit still clocked");

    chk_halt_stops: assert property ( // see RULE_08
        @(posedge clk) disable iff (!rst_n)
        halt_s2_q |=> (!proc_tick_q && periph_en_q == '0))
        else $error("clock ran during halt");

    chk_gap_quiet: assert property ( // see RULE_09
        @(posedge clk) disable iff (!rst_n)
        (state_q != ST_GAP && state_d == ST_GAP) |=> ##1 !proc_tick_q ##1 !proc_tick_q)
        else $error("tick during source change");

endmodule

// ---- sim/pcss_lock_model.sv ----
// synthesizer lock source model for the clock input side
`timescale 1ns/1ns
module pcss_lock_model (
    input  wire logic clk,
    input  wire logic pwr_en,
    output logic      lock_pin
);
    logic [3:0] cnt_q;
    // lock comes a while after power, drops at once without it
    always_ff @(posedge clk) begin
        if (!pwr_en) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    assign lock_pin = pwr_en && (cnt_q == 4'hf);
endmodule

// ---- sim/pcss_top_tb.sv ----
// self-checking bench for the clock source select block
`timescale 1ns/1ns
module pcss_top_tb;
    import pcss_pkg::*;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    pcss_ctl_t         ctl = '0;
    logic              halt_pin = 1'b0;
    logic              lock;
    logic              proc_tick_q;
    logic [UNIT_W-1:0] periph_en_q;
    pcss_stat_t        stat;
    int                fails = 0;
    int                comparisons = 0;
    int                n;

    always #20 clk = ~clk;

    pcss_lock_model u_lock (.clk(clk), .pwr_en(stat.synth_pwr_en), .lock_pin(lock));
    pcss_top dut (.clk(clk), .arst_n(arst_n), .ctl(ctl), .halt_pin(halt_pin),
        .synth_lock_pin(lock), .proc_tick_q(proc_tick_q), .periph_en_q(periph_en_q),
        .stat(stat));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wait_src(input pcss_src_t s);
        for (int i = 0; i < 40 && stat.src !== s; i++) @(negedge clk);
        chk(16'(stat.src), 16'(s));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cyc(3);
        chk(16'(proc_tick_q), 16'h0000);
        @(posedge clk);
        arst_n <= 1'b1;
        cyc(4);
        chk(16'(proc_tick_q), 16'h0001);
        chk(16'(stat.src), 16'(SRC_EXT));
        chk(16'({stat.synth_pwr_en, stat.synth_mult}), 16'h0001);
        $display("reset test done");
    endtask

    task automatic t_synth();
        @(posedge clk);
        ctl.synth_pwr_req <= 1'b1;
        ctl.synth_sel_req <= 1'b1;
        ctl.synth_mult    <= 4'h3;
        wait_src(SRC_SYNTH);
        chk(16'(stat.synth_mult), 16'h0003);
        cyc(1);
        chk(16'(proc_tick_q), 16'h0001);
        $display("synth test done");
    endtask

    task automatic t_slow();
        @(posedge clk);
        ctl.slow_sel_req <= 1'b1;
        for (int i = 0; i < 10 && stat.switching !== 1'b1; i++) @(negedge clk);
        chk(16'(stat.switching), 16'h0001);
        cyc(1);
        chk(16'(proc_tick_q), 16'h0000);
        wait_src(SRC_SLOW);
        chk(16'({stat.synth_pwr_en, stat.synth_locked}), 16'h0003);
        n = 0;
        repeat (2 * SLOW_DIV) begin
            @(negedge clk);
            n += int'(proc_tick_q === 1'b1);
        end
        chk(16'(n), 16'h0002);
        @(posedge clk);
        ctl.slow_sel_req <= 1'b0;
        wait_src(SRC_SYNTH);
        $display("slow test done");
    endtask

    task automatic t_gate_halt();
        @(posedge clk);
        ctl.unit_gate <= 8'h0f;
        cyc(3);
        chk(16'(periph_en_q), 16'h00f0);
        @(posedge clk);
        halt_pin <= 1'b1;
        cyc(4);
        chk(16'({proc_tick_q, periph_en_q}), 16'h0000);
        @(posedge clk);
        halt_pin <= 1'b0;
        cyc(4);
        chk(16'(proc_tick_q), 16'h0001);
        $display("gate and halt test done");
    endtask

    // reset in mid-run must drop a running synthesizer
    task automatic t_rereset();
        @(posedge clk);
        arst_n <= 1'b0;
        ctl    <= '0;
        cyc(2);
        chk(16'(stat.src), 16'(SRC_EXT));
        chk(16'(stat.synth_pwr_en), 16'h0000);
        chk(16'(proc_tick_q), 16'h0000);
        @(posedge clk);
        arst_n <= 1'b1;
        cyc(4);
        chk(16'(proc_tick_q), 16'h0001);
        chk(16'(stat.src), 16'(SRC_EXT));
        chk(16'(stat.synth_mult), 16'(MULT_RST));
        $display("mid-run reset test done");
    endtask

    initial begin
        t_reset();
        t_synth();
        t_slow();
        t_gate_halt();
        t_rereset();
        end_sim();
    end

    initial begin
        #100000;
        fails++;
        end_sim();
    end
endmodule
